//--- tb/gas_probe_sva.sv
/* Port assertions of the probe protection sequencer.
   Assumes it is bound into every sequencer instance. */
`timescale 1ns/10ps
module gas_probe_sva (
  input wire logic        clk,              // Clock
  input wire logic        rst,              // Reset
  input wire logic        zeroValveOpen,    // Valve
  input wire logic        funcControl,      // Function control
  input wire logic        displayBlank,     // Asterisks
  input wire logic        indicatorH,       // Letter H
  input wire logic [15:0] displayValue,     // Shown value
  input wire logic        faultLogged,      // Fault
  input wire logic        measuringMode,    // Mode
  input wire logic        otherStateStart,  // Abort
  input wire logic        chopperOff,       // Chopper off
  input wire logic        irSourceOff,      // IR off
  input wire logic        measReady,        // Ready
  input wire logic        s_axi_arvalid,    // Read addr valid
  input wire logic        s_axi_arready,    // Read addr ready
  input wire logic        s_axi_rvalid      // Read valid
);
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sEnter; $rose(funcControl); endsequence
  sequence sRelight; $fell(chopperOff) && !irSourceOff; endsequence
  a_flag_group: assert property ((funcControl == displayBlank) &&
    (funcControl == indicatorH) && (!zeroValveOpen || funcControl)) else $error("flags split");
  a_blank_zero: assert property (displayBlank && $past(displayBlank)
    |-> displayValue == 16'h0000) else $error("value shown while blank");
  a_mode_trig: assert property (sEnter |-> $past(measuringMode, 3)
    && $past(measuringMode, 8)) else $error("trigger outside measuring mode");
  a_other_abort: assert property (otherStateStart |-> ##[1:3]
    (!zeroValveOpen && !funcControl)) else $error("abort ignored");
  a_fault_valve: assert property ($rose(faultLogged) |-> ##[0:2] zeroValveOpen)
    else $error("fault without valve");
  a_chop_ready: assert property ((chopperOff || irSourceOff) |-> ##[0:2] !measReady)
    else $error("ready while off");
  a_warm_hold: assert property (sRelight |-> !measReady [*8])
    else $error("no warm-up");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read not answered");
endmodule
bind gas_probe_protection_sequencer gas_probe_sva u_gas_probe_sva (.*);

//--- tb/probe_gas_model.sv
/* Probe and zero gas valve model for the far side of the sequencer.
   Assumes gasLevel is the sample concentration chosen by the bench. */
`timescale 1ns/10ps
module probe_gas_model #(
  parameter logic [15:0] ZERO_READ = 16'h0003  // Reading on zero gas
) (
  input  wire logic        clk,            // Clock
  input  wire logic        rst,            // Reset
  input  wire logic        zeroValveOpen,  // Valve drive
  input  wire logic [15:0] gasLevel,       // Sample concentration
  output logic      [15:0] measValue       // Probe reading
);
  // ****************************************************
  // Gas path
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) measValue <= 16'h0000;
    else measValue <= zeroValveOpen ? ZERO_READ : gasLevel;
  end
endmodule

//--- tb/test_gas_probe_protection_sequencer.sv
/* Self-checking bench of the probe protection sequencer.
   Assumes the probe model and the port checker beside it. */
`timescale 1ns/10ps
module test_gas_probe_protection_sequencer;
  import gas_probe_pkg::*;
  localparam int SEC = 20;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, measuringMode, otherStateStart, calInput, pumpInput;
  logic        syncInput, boardPresent, zeroValveOpen, funcControl, displayBlank;
  logic        indicatorH, faultLogged, chopperOff, irSourceOff, measReady;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, binInputs;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] measValue, displayValue, gasLevel;
  logic [65:0] expQ[$];
  logic [65:0] ent;
  logic [2:0]  pat[4] = '{3'b000, 3'b111, 3'b110, 3'b100};
  int          bad_count, cmp_count, n, k;

  gas_probe_protection_sequencer #(.SEC_CYCLES(SEC)) u_gas_probe_protection_sequencer (.*);
  probe_gas_model u_probe_gas_model (.clk(clk), .rst(rst), .zeroValveOpen(zeroValveOpen),
    .gasLevel(gasLevel), .measValue(measValue));

  // ****************************************************
  // Helpers
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic flag(input string nm, input logic seen, input logic exp);
    check(nm, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    i = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      i++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && i < 50);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    int i;
    i = 0;
    expQ.push_back({er, m, e});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      i++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && i < 50);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && expQ.size() > 0) begin
      ent = expQ.pop_front();
      check("rdata", s_axi_rdata & ent[63:32], ent[31:0]);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, ent[65:64]});
    end
  end
  function automatic logic sig(input int i);
    case (i)
      0: return zeroValveOpen;
      1: return funcControl;
      2: return faultLogged;
      default: return measReady;
    endcase
  endfunction
  task automatic waitSig(input int i, input logic v, input int lim, output int c);
    c = 0;
    while (sig(i) !== v && c < lim) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic trip(input logic [15:0] lvl, output int c);
    @(posedge clk);
    gasLevel <= lvl;
    waitSig(0, 1'b1, 200, c);
  endtask
  task automatic abortOther();
    @(posedge clk);
    gasLevel <= 16'h0100;
    otherStateStart <= 1'b1;
    @(posedge clk);
    otherStateStart <= 1'b0;
    repeat (3) @(posedge clk);
    flag("abort", zeroValveOpen, 1'b0);
  endtask
  task automatic quiet(input logic [15:0] lvl);
    @(posedge clk);
    gasLevel <= lvl;
    repeat (150) @(posedge clk);
    flag("quiet", zeroValveOpen, 1'b0);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {otherStateStart, calInput, pumpInput, syncInput, boardPresent} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, binInputs, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    measuringMode = 1'b1;
    gasLevel = 16'h0000;
    void'($urandom(77811));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL, 32'h1, 32'hf, RESP_OKAY);
    rd(OFF_RANGE, 32'h1f4, 32'h1ffff, RESP_OKAY);
    rd(OFF_PURGE, 32'h12c, 32'hffff, RESP_OKAY);
    rd(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h44, 32'h1, RESP_SLVERR);
    wr(OFF_PURGE, 32'h2, RESP_OKAY);
    repeat (120) begin
      @(posedge clk);
      gasLevel <= 16'($urandom_range(550, 400));
    end
    quiet(16'h0226);
    trip(16'h0227, n);
    flag("qualify", n > 40 && n < 100, 1'b1);
    gasLevel <= 16'h0100;
    rd(OFF_STATUS, 32'h2, 32'h7, RESP_OKAY);
    flag("fctrl", funcControl, 1'b1);
    flag("blank", displayBlank, 1'b1);
    flag("letter", indicatorH, 1'b1);
    check("shown", {16'h0, displayValue}, 32'h0);
    waitSig(0, 1'b0, 300, n);
    flag("zero purge", n > 50 && n < 102, 1'b1);
    waitSig(1, 1'b0, 200, n);
    flag("sample purge", n > 19 && n < 62, 1'b1);
    repeat (3) @(posedge clk);
    flag("letter end", indicatorH, 1'b0);
    check("restored", {16'h0, displayValue}, 32'h100);
    trip(16'h0227, n);
    waitSig(2, 1'b1, 1500, n);
    flag("repeats", n > 500 && n < 720, 1'b1);
    repeat (100) @(posedge clk);
    flag("hold", zeroValveOpen, 1'b1);
    rd(OFF_STATUS, 32'h1c64, 32'hffff, RESP_OKAY);
    @(posedge clk);
    gasLevel <= 16'h0100;
    wr(OFF_CMD, 32'h1, RESP_OKAY);
    repeat (3) @(posedge clk);
    flag("ack", faultLogged, 1'b0);
    flag("ack valve", zeroValveOpen, 1'b0);
    trip(16'h0227, n);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    flag("off", funcControl, 1'b0);
    quiet(16'h0227);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    trip(16'h0227, n);
    abortOther();
    measuringMode <= 1'b0;
    quiet(16'h0227);
    measuringMode <= 1'b1;
    wr(OFF_RANGE, 32'h101f4, RESP_OKAY);
    quiet(16'h007d);
    trip(16'h007e, n);
    flag("probe50", zeroValveOpen, 1'b1);
    abortOther();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {syncInput, pumpInput, calInput} <= pat[i];
      rd(OFF_INTEST, i, 32'h1ff, RESP_OKAY);
    end
    wr(OFF_CTRL, 32'h9, RESP_OKAY);
    rd(OFF_INTEST, 32'h100, 32'h100, RESP_OKAY);
    k = $urandom_range(7, 0);
    boardPresent <= 1'b1;
    binInputs <= 8'h01 << k;
    rd(OFF_INTEST, k + 1, 32'h1ff, RESP_OKAY);
    wr(OFF_FACTORY, 32'h1234, RESP_SLVERR);
    wr(OFF_CODE, 32'h1111, RESP_OKAY);
    rd(OFF_CODE, 32'h0, 32'h1, RESP_OKAY);
    wr(OFF_CODE, {16'h0, ACCESS_CODE}, RESP_OKAY);
    rd(OFF_CODE, 32'h1, 32'h1, RESP_OKAY);
    wr(OFF_FACTORY, 32'h1234, RESP_OKAY);
    rd(OFF_FACTORY, 32'h1234, 32'hffff, RESP_OKAY);
    wr(OFF_CTRL, 32'h7, RESP_OKAY);
    repeat (3) @(posedge clk);
    flag("chopper", chopperOff && irSourceOff && !measReady, 1'b1);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    waitSig(3, 1'b1, 1500, n);
    flag("warm-up", n > 1150 && n < 1250, 1'b1);
    summarize();
  end
  initial begin
    #150000;
    bad_count++;
    summarize();
  end
endmodule

//--- verilog/gas_probe_pkg.sv
/*
  Constants shared by the probe protection sequencer and its testbench.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package gas_probe_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned QUAL_TIME_S  = 3;
  localparam logic [3:0]  MAX_REPEATS  = 4'h6;
  localparam logic [15:0] WARMUP_S_RST = 16'h003c;

  // ****************************************************
  // Threshold scaling (values in 0.1 vpm units)
  // ****************************************************
  localparam logic [3:0]  THR_NUM      = 4'hb;
  localparam logic [3:0]  THR_DEN      = 4'ha;
  localparam logic [15:0] PROBE50_THR  = 16'h007d;
  localparam logic [15:0] FAULT_CODE   = 16'h001c;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CMD     = 8'h04;
  localparam logic [7:0] OFF_RANGE   = 8'h08;
  localparam logic [7:0] OFF_PURGE   = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_DISPLAY = 8'h14;
  localparam logic [7:0] OFF_INTEST  = 8'h18;
  localparam logic [7:0] OFF_CODE    = 8'h1c;
  localparam logic [7:0] OFF_FACTORY = 8'h20;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_CHOPOFF = 1;
  localparam int CTRL_IROFF   = 2;
  localparam int CTRL_BINSEL  = 3;
  localparam int CMD_ACK      = 0;
  localparam int RANGE_P50    = 16;

  // ****************************************************
  // Reset values and access code
  // ****************************************************
  localparam logic [3:0]  CTRL_RST     = 4'h1;
  localparam logic [16:0] RANGE_RST    = 17'h001f4;
  localparam logic [15:0] PURGE_RST    = 16'h012c;
  localparam logic [15:0] FACTORY_RST  = 16'h0000;
  localparam logic [15:0] ACCESS_CODE  = 16'h5a3c; // Arbitrary value

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    StIdle, StQualify, StZeroPurge, StSamplePurge, StFaultHold
  } prot_state_type;

endpackage

//--- verilog/gas_probe_protection_sequencer.sv
/*
  Probe protection sequencer with AXI4-Lite registers, input test reporting,
  chopper and IR source switch-off with warm-up, and factory access gating.
  Assumes measured value and status inputs synchronous to clk.
*/
`timescale 1ns/10ps
module gas_probe_protection_sequencer
  import gas_probe_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = TICK_CYCLES
) (
  input  wire logic        clk,             // System clock
  input  wire logic        rst,             // Async reset, active high
  input  wire logic [7:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [7:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic [15:0] measValue,       // Continuous value, 0.1 vpm
  input  wire logic        measuringMode,   // Device in measuring mode
  input  wire logic        otherStateStart, // Calibration or zero cal start
  input  wire logic        calInput,        // Calibration input level
  input  wire logic        pumpInput,       // Pump input level
  input  wire logic        syncInput,       // Sync input level
  input  wire logic [7:0]  binInputs,       // Add-on board binary inputs
  input  wire logic        boardPresent,    // Add-on board fitted
  output logic             zeroValveOpen,   // Zero gas valve drive
  output logic             funcControl,     // Function control status
  output logic             displayBlank,    // Show asterisks for value
  output logic             indicatorH,      // Indicator letter H
  output logic [15:0]      displayValue,    // Value shown, zero if blank
  output logic             faultLogged,     // Probe protection fault
  output logic             chopperOff,      // Chopper switched off
  output logic             irSourceOff,     // IR source switched off
  output logic             measReady        // Measuring readiness
);

  // ****************************************************
  // Decoding helpers
  // ****************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0]  = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction

  function automatic logic [4:0] firstActive(input logic [7:0] v);
    logic [4:0] code;
    code = 5'h00;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) code = 5'(i + 1);
    end
    return code;
  endfunction

  // ****************************************************
  // Register state
  // ****************************************************
  logic [3:0]     ctrl_q;
  logic [16:0]    range_q;
  logic [15:0]    purge_q;
  logic [15:0]    factory_q;
  logic           granted_q;
  logic [15:0]    warm_q;
  logic           ackPulse;
  logic           wrFire;
  logic [7:0]     awAddr_q;
  logic [31:0]    wData_q;
  logic [3:0]     wStrb_q;
  prot_state_type state_q;
  logic [16:0]    timer_q;
  logic [3:0]     repeat_q;
  logic [4:0]     inCode_q;
  logic           boardMissing_q;
  logic           secRaw;
  logic           secTick;
  logic           warmTick;
  logic           timerClr;
  logic           abortReq;
  logic           above;
  logic [19:0]    lhs;
  logic [20:0]    rhs;

  // ****************************************************
  // AXI4-Lite write channel
  // ****************************************************
  assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddr_q      <= '0;
      wData_q       <= '0;
      wStrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        unique case (awAddr_q)
          OFF_CTRL, OFF_CMD, OFF_RANGE, OFF_PURGE, OFF_CODE:
            s_axi_bresp <= RESP_OKAY;
          OFF_FACTORY: s_axi_bresp <= granted_q ? RESP_OKAY : RESP_SLVERR;
          default:     s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign ackPulse = wrFire && awAddr_q == OFF_CMD && wStrb_q[0] && wData_q[CMD_ACK];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wrFire && awAddr_q == OFF_CTRL && wStrb_q[0]) begin
      ctrl_q <= wData_q[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      range_q <= RANGE_RST;
      purge_q <= PURGE_RST;
    end else if (wrFire) begin
      if (awAddr_q == OFF_RANGE) begin
        range_q[15:0] <= merge16(range_q[15:0], wData_q, wStrb_q);
        if (wStrb_q[2]) range_q[RANGE_P50] <= wData_q[RANGE_P50];
      end
      if (awAddr_q == OFF_PURGE) purge_q <= merge16(purge_q, wData_q, wStrb_q);
    end
  end

  // ****************************************************
  // Factory configuration access
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      granted_q <= 1'b0;
      factory_q <= FACTORY_RST;
    end else if (wrFire) begin
      if (awAddr_q == OFF_CODE && wStrb_q[1:0] == 2'b11) begin
        granted_q <= wData_q[15:0] == ACCESS_CODE;
      end
      if (awAddr_q == OFF_FACTORY && granted_q) begin
        factory_q <= merge16(factory_q, wData_q, wStrb_q);
      end
    end
  end

  // ****************************************************
  // AXI4-Lite read channel
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL:    s_axi_rdata <= {28'h0, ctrl_q};
        OFF_CMD:     s_axi_rdata <= 32'h0;
        OFF_RANGE:   s_axi_rdata <= {15'h0, range_q};
        OFF_PURGE:   s_axi_rdata <= {16'h0, purge_q};
        OFF_STATUS:  s_axi_rdata <= {16'h0, faultLogged ? FAULT_CODE[7:0] : 8'h00,
                                     repeat_q, 1'b0, 3'(state_q)};
        OFF_DISPLAY: s_axi_rdata <= {displayBlank, 8'h0, measReady, indicatorH,
                                     funcControl, zeroValveOpen, 3'h0, displayValue};
        OFF_INTEST:  s_axi_rdata <= {23'h0, boardMissing_q, 3'h0, inCode_q};
        OFF_CODE:    s_axi_rdata <= {31'h0, granted_q};
        OFF_FACTORY: s_axi_rdata <= granted_q ? {16'h0, factory_q} : 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************
  // Threshold comparison
  // ****************************************************
  assign lhs = 20'(measValue) * 20'(THR_DEN);
  assign rhs = range_q[RANGE_P50] ? 21'(PROBE50_THR) * 21'(THR_DEN)
                                  : 21'(range_q[15:0]) * 21'(THR_NUM);
  assign above = {1'b0, lhs} > rhs;

  // ****************************************************
  // Protection sequencer
  // ****************************************************
  assign abortReq = !ctrl_q[CTRL_ENABLE] || otherStateStart || ackPulse;

  seconds_tick #(
    .DIV (SEC_CYCLES)
  ) u_sec (
    .clk  (clk),
    .rst  (rst),
    .clr  (timerClr),
    .tick (secRaw)
  );

  // Drop a tick that was already counted before the restart took effect
  assign secTick = secRaw && !timerClr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= StIdle;
      timer_q  <= '0;
      repeat_q <= '0;
      timerClr <= 1'b1;
    end else begin
      timerClr <= 1'b0;
      if (abortReq && state_q != StIdle) begin
        state_q  <= StIdle;
        timer_q  <= '0;
        repeat_q <= '0;
        timerClr <= 1'b1;
      end else begin
        unique case (state_q)
          StIdle: begin
            if (above && measuringMode && !abortReq) begin
              state_q  <= StQualify;
              timer_q  <= '0;
              timerClr <= 1'b1;
            end
          end
          StQualify: begin
            if (!above || !measuringMode) begin
              state_q <= StIdle;
            end else if (secTick) begin
              if (timer_q == 17'(QUAL_TIME_S - 1)) begin
                state_q  <= StZeroPurge;
                timer_q  <= '0;
                repeat_q <= '0;
              end else begin
                timer_q <= timer_q + 17'h1;
              end
            end
          end
          StZeroPurge: begin
            if (secTick) begin
              if (timer_q >= {purge_q, 1'b0} - 17'h1) begin
                state_q <= StSamplePurge;
                timer_q <= '0;
              end else begin
                timer_q <= timer_q + 17'h1;
              end
            end
          end
          StSamplePurge: begin
            if (above) begin
              timer_q  <= '0;
              timerClr <= 1'b1;
              if (repeat_q == MAX_REPEATS) begin
                state_q <= StFaultHold;
              end else begin
                state_q  <= StZeroPurge;
                repeat_q <= repeat_q + 4'h1;
              end
            end else if (secTick) begin
              if (timer_q >= {1'b0, purge_q} - 17'h1) begin
                state_q  <= StIdle;
                repeat_q <= '0;
              end else begin
                timer_q <= timer_q + 17'h1;
              end
            end
          end
          StFaultHold: begin
            state_q <= StFaultHold;
          end
          default: state_q <= StIdle;
        endcase
      end
    end
  end

  // ****************************************************
  // Protection outputs
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zeroValveOpen <= 1'b0;
      funcControl   <= 1'b0;
      displayBlank  <= 1'b0;
      indicatorH    <= 1'b0;
      displayValue  <= '0;
    end else begin
      zeroValveOpen <= state_q == StZeroPurge || state_q == StFaultHold;
      funcControl   <= state_q inside {StZeroPurge, StSamplePurge, StFaultHold};
      displayBlank  <= state_q inside {StZeroPurge, StSamplePurge, StFaultHold};
      indicatorH    <= state_q inside {StZeroPurge, StSamplePurge, StFaultHold};
      displayValue  <= (state_q inside {StZeroPurge, StSamplePurge, StFaultHold})
                       ? 16'h0000 : measValue;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultLogged <= 1'b0;
    end else if (state_q == StSamplePurge && above && repeat_q == MAX_REPEATS) begin
      faultLogged <= 1'b1;
    end else if (ackPulse) begin
      faultLogged <= 1'b0;
    end
  end

  // ****************************************************
  // Input test
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inCode_q       <= '0;
      boardMissing_q <= 1'b0;
    end else if (ctrl_q[CTRL_BINSEL]) begin
      boardMissing_q <= !boardPresent;
      inCode_q       <= boardPresent ? firstActive(binInputs) : 5'h00;
    end else begin
      boardMissing_q <= 1'b0;
      inCode_q       <= firstActive({5'h00, syncInput, pumpInput, calInput});
    end
  end

  // ****************************************************
  // Chopper, IR source and warm-up
  // ****************************************************
  seconds_tick #(
    .DIV (SEC_CYCLES)
  ) u_warm (
    .clk  (clk),
    .rst  (rst),
    .clr  (ctrl_q[CTRL_CHOPOFF] || ctrl_q[CTRL_IROFF]),
    .tick (warmTick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chopperOff  <= 1'b0;
      irSourceOff <= 1'b0;
      warm_q      <= '0;
      measReady   <= 1'b1;
    end else begin
      chopperOff  <= ctrl_q[CTRL_CHOPOFF];
      irSourceOff <= ctrl_q[CTRL_IROFF];
      if (ctrl_q[CTRL_CHOPOFF] || ctrl_q[CTRL_IROFF]) begin
        warm_q    <= '0;
        measReady <= 1'b0;
      end else if (!measReady && warmTick) begin
        if (warm_q == WARMUP_S_RST - 16'h1) begin
          measReady <= 1'b1;
        end else begin
          warm_q <= warm_q + 16'h1;
        end
      end
    end
  end

endmodule

//--- verilog/seconds_tick.sv
/*
  Divider producing a one-cycle enable pulse every DIV clock cycles.
  Assumes synchronous clear from the owner whenever its timing restarts.
*/
`timescale 1ns/10ps
module seconds_tick #(
  parameter int unsigned DIV = 200_000_000
) (
  input  wire logic clk,   // System clock
  input  wire logic rst,   // Async reset, active high
  input  wire logic clr,   // Restart the period
  output logic      tick   // One-cycle pulse
);

  logic [27:0] count_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (clr) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (count_q == 28'(DIV - 1)) begin
      count_q <= '0;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 28'h1;
      tick    <= 1'b0;
    end
  end

endmodule
